// >>> hdl/ebrt_params.svh
/*
 Constants for the eight-bit reload timer register block: offsets, field positions,
 reset values. Assumes inclusion by bare name from the design and the testbench.
*/
`ifndef EBRT_PARAMS_SVH
`define EBRT_PARAMS_SVH
`define EBRT_IDX_IRQ_ALLOW 24'h00FF24
`define EBRT_IDX_PENDING 24'h00FF28
`define EBRT_IDX_CONTROL 24'h00FF38
`define EBRT_IDX_RELOAD 24'h00FF39
`define EBRT_IDX_SNAPSHOT 24'h00FF3A
`define EBRT_IDX_TIMER_DIV 24'h00FF40
`define EBRT_BIT_UNDERFLOW 3'h7
`define EBRT_BIT_GATE 2'h2
`define EBRT_BIT_PRESET 2'h1
`define EBRT_BIT_RUN 2'h0
`define EBRT_RELOAD_RESET 8'hFF
`define EBRT_SNAPSHOT_RESET 8'hFF
`define EBRT_DIV_RESET 8'h01
`endif

// >>> hdl/ebrt_pkg.sv
/*
 Types for the eight-bit reload timer register block.
 Assumes the params header is on the include path.
*/
package ebrt_pkg;
  typedef struct packed {
    logic read;
    logic write;
    logic [25:0] address;
    logic [31:0] writedata;
  } ebrt_req_t;
  typedef enum logic [1:0] {EBRT_IDLE, EBRT_ANSWER} ebrt_bus_state_t;
endpackage

// >>> hdl/ebrt_timer.sv
/*
 Eight-bit down-counting reload timer with Avalon-MM register slave, a
 sticky underflow flag with write-one-clear, and a halved underflow clock
 for the serial interface. Assumes one 50 MHz clock and synchronous reset;
 the timer clock is an enable pulse from an internal divider.
*/
// How it works
// - Control bit two gates the halved underflow clock out; resets zero.
// - Control bit one written one presets counter from reload; reads zero.
// - Control bit zero runs or halts the counter, keeping its value; resets zero.
// - Underflow sets pending bit seven; write one clears; resets zero.
// - Reload value loads on preset and underflow; readable; resets all ones.
// - Count snapshot is a stable read-only buffer, resets all ones.
// - Serial clock toggles on each underflow, one period per two underflows.
// - Interrupt only when allow bit set; flag sets regardless.
`timescale 1ns/100ps
`include "ebrt_params.svh"
module ebrt_timer
  import ebrt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [25:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic serial_clock_out,
  output logic irq
);
  ebrt_req_t req;
  ebrt_bus_state_t state_q;
  logic [7:0] count_q;
  logic [7:0] reload_value_q;
  logic [7:0] count_snapshot_q;
  logic [7:0] irq_allow_q;
  logic [7:0] pending_q;
  logic [7:0] div_q;
  logic [7:0] div_cnt_q;
  logic serial_clock_output_gate_q;
  logic count_run_control_q;
  logic half_clk_q;
  logic tick;
  logic underflow;
  logic wr_take;
  logic lane0;
  logic [31:0] rdata_d;

  function automatic logic hit(input logic [25:0] a, input logic [23:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};
  // One wait cycle per access; the request is taken at the edge waitrequest is low
  assign avs_waitrequest = (req.read || req.write) && (state_q == EBRT_IDLE);
  assign wr_take = req.write && (state_q == EBRT_ANSWER);
  assign lane0 = avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= EBRT_IDLE;
    end else begin
      case (state_q)
        EBRT_IDLE: if (req.read || req.write) state_q <= EBRT_ANSWER;
        default: state_q <= EBRT_IDLE;
      endcase
    end
  end

  // Timer clock stand-in for the prescaler: enable every div_q+1 cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt_q <= 8'h00;
    end else if (div_cnt_q >= div_q) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end
  assign tick = (div_cnt_q >= div_q);

  assign underflow = tick && count_run_control_q && (count_q == 8'h00);

  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= `EBRT_RELOAD_RESET;
    end else if (wr_take && lane0 && hit(req.address, `EBRT_IDX_CONTROL)
                 && req.writedata[`EBRT_BIT_PRESET]) begin
      count_q <= reload_value_q;
    end else if (underflow) begin
      count_q <= reload_value_q;
    end else if (tick && count_run_control_q) begin
      count_q <= count_q - 8'h01;
    end
  end

  // Snapshot frozen during a read so a bus read never sees a half-updated count
  always_ff @(posedge clk) begin
    if (reset) begin
      count_snapshot_q <= `EBRT_SNAPSHOT_RESET;
    end else if (!req.read) begin
      count_snapshot_q <= count_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      serial_clock_output_gate_q <= 1'b0;
      count_run_control_q <= 1'b0;
    end else if (wr_take && lane0 && hit(req.address, `EBRT_IDX_CONTROL)) begin
      serial_clock_output_gate_q <= req.writedata[`EBRT_BIT_GATE];
      count_run_control_q <= req.writedata[`EBRT_BIT_RUN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reload_value_q <= `EBRT_RELOAD_RESET;
      irq_allow_q <= 8'h00;
      div_q <= `EBRT_DIV_RESET;
    end else if (wr_take && lane0) begin
      if (hit(req.address, `EBRT_IDX_RELOAD)) begin
        reload_value_q <= req.writedata[7:0];
      end else if (hit(req.address, `EBRT_IDX_IRQ_ALLOW)) begin
        irq_allow_q <= req.writedata[7:0];
      end else if (hit(req.address, `EBRT_IDX_TIMER_DIV)) begin
        div_q <= req.writedata[7:0];
      end
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      pending_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (underflow && i == `EBRT_BIT_UNDERFLOW) begin
          pending_q[i] <= 1'b1;
        end else if (wr_take && lane0 && hit(req.address, `EBRT_IDX_PENDING)
                     && req.writedata[i]) begin
          pending_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      half_clk_q <= 1'b0;
    end else if (underflow) begin
      half_clk_q <= ~half_clk_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      serial_clock_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      serial_clock_out <= half_clk_q && serial_clock_output_gate_q;
      irq <= |(pending_q & irq_allow_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(req.address, `EBRT_IDX_CONTROL)) begin
      // Preset reads zero, upper bits zero
      rdata_d[2:0] = {serial_clock_output_gate_q, 1'b0, count_run_control_q};
    end else if (hit(req.address, `EBRT_IDX_RELOAD)) begin
      rdata_d[7:0] = reload_value_q;
    end else if (hit(req.address, `EBRT_IDX_SNAPSHOT)) begin
      rdata_d[7:0] = count_snapshot_q;
    end else if (hit(req.address, `EBRT_IDX_PENDING)) begin
      rdata_d[7:0] = pending_q;
    end else if (hit(req.address, `EBRT_IDX_IRQ_ALLOW)) begin
      rdata_d[7:0] = irq_allow_q;
    end else if (hit(req.address, `EBRT_IDX_TIMER_DIV)) begin
      rdata_d[7:0] = div_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req.read && state_q == EBRT_IDLE) begin
      avs_readdata <= rdata_d;
    end
  end

  sequence s_underflow;
    underflow;
  endsequence

  AST_GATE_OFF: assert property (@(posedge clk) disable iff (reset)
    !serial_clock_output_gate_q |=> !serial_clock_out)
    else $error("serial clock forwarded while gate off");
  AST_PRESET_LOAD: assert property (@(posedge clk) disable iff (reset)
    (wr_take && lane0 && hit(req.address, `EBRT_IDX_CONTROL) && req.writedata[1])
      |=> count_q == $past(reload_value_q))
    else $error("preset did not load reload value");
  AST_RUN_HOLD: assert property (@(posedge clk) disable iff (reset)
    (!count_run_control_q && !wr_take) |=> $stable(count_q))
    else $error("counter moved while halted");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (reset)
    s_underflow |=> pending_q[7])
    else $error("pending flag not set on underflow");
  AST_UNDERFLOW_RELOAD: assert property (@(posedge clk) disable iff (reset)
    (s_underflow and !wr_take) |=> count_q == $past(reload_value_q))
    else $error("underflow did not reload");
  AST_SNAP_STABLE: assert property (@(posedge clk) disable iff (reset)
    req.read ##1 req.read |-> $stable(count_snapshot_q))
    else $error("snapshot changed during read");
  AST_HALF_CLOCK: assert property (@(posedge clk) disable iff (reset)
    s_underflow |=> half_clk_q != $past(half_clk_q))
    else $error("half clock did not toggle");
  AST_IRQ_ALLOW: assert property (@(posedge clk) disable iff (reset)
    !irq_allow_q[7] && !(|(pending_q[6:0] & irq_allow_q[6:0])) |=> !irq)
    else $error("interrupt raised while not allowed");
  AST_CTRL_UPPER: assert property (@(posedge clk) disable iff (reset)
    hit(req.address, `EBRT_IDX_CONTROL) |-> rdata_d[7:1] == 7'h00
      || rdata_d[7:3] == 5'h00 && !rdata_d[1])
    else $error("control upper bits not zero");

  // Bus and flag behaviours as named sequences, single-cycle except s_held_request
  sequence s_bus_start;
    (req.read || req.write) && state_q == EBRT_IDLE;
  endsequence

  sequence s_held_request;
    s_bus_start ##1 (req.read || req.write);
  endsequence

  sequence s_ctrl_write;
    wr_take && lane0 && hit(req.address, `EBRT_IDX_CONTROL);
  endsequence

  sequence s_reload_write;
    wr_take && lane0 && hit(req.address, `EBRT_IDX_RELOAD);
  endsequence

  sequence s_flag_clear;
    wr_take && lane0 && hit(req.address, `EBRT_IDX_PENDING) && req.writedata[7];
  endsequence

  sequence s_ctrl_read;
    s_bus_start ##0 (req.read && hit(req.address, `EBRT_IDX_CONTROL));
  endsequence

  sequence s_snap_read;
    s_bus_start ##0 (req.read && hit(req.address, `EBRT_IDX_SNAPSHOT));
  endsequence

  // A master holding its request must be answered in the second cycle
  AST_BUS_ONE_WAIT: assert property (@(posedge clk) disable iff (reset)
    s_held_request |-> !avs_waitrequest)
    else $error("bus stalled past its single wait cycle");

  AST_GATE_ON: assert property (@(posedge clk) disable iff (reset)
    serial_clock_output_gate_q |=> serial_clock_out == $past(half_clk_q))
    else $error("serial clock not forwarded while gate on");

  AST_CTRL_READBACK: assert property (@(posedge clk) disable iff (reset)
    s_ctrl_read |=> avs_readdata[31:3] == 29'h0 && !avs_readdata[`EBRT_BIT_PRESET])
    else $error("control read returned preset or upper bits");

  AST_RUN_BIT_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_ctrl_write |=> count_run_control_q == $past(avs_writedata[`EBRT_BIT_RUN]))
    else $error("run bit did not take the written value");

  AST_RUN_COUNT: assert property (@(posedge clk) disable iff (reset)
    (tick && count_run_control_q && count_q != 8'h00 && !wr_take)
      |=> count_q == $past(count_q) - 8'h01)
    else $error("running counter did not decrement on tick");

  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (s_flag_clear ##0 !underflow) |=> !pending_q[`EBRT_BIT_UNDERFLOW])
    else $error("write one did not clear the pending flag");

  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (reset)
    (pending_q[`EBRT_BIT_UNDERFLOW] && !wr_take) |=> pending_q[`EBRT_BIT_UNDERFLOW])
    else $error("pending flag dropped without a clear");

  AST_FLAG_NO_EVENT: assert property (@(posedge clk) disable iff (reset)
    (!underflow && !pending_q[`EBRT_BIT_UNDERFLOW]) |=> !pending_q[`EBRT_BIT_UNDERFLOW])
    else $error("pending flag set with no underflow");

  AST_RELOAD_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_reload_write |=> reload_value_q == $past(avs_writedata[7:0]))
    else $error("reload register did not take the written value");

  // Lane zero off must leave the reload register untouched
  AST_LANE_OFF: assert property (@(posedge clk) disable iff (reset)
    (wr_take && !lane0) |=> $stable(reload_value_q))
    else $error("reload changed on a write with lane zero off");

  AST_SNAP_FOLLOW: assert property (@(posedge clk) disable iff (reset)
    !req.read |=> count_snapshot_q == $past(count_q))
    else $error("snapshot did not follow the count outside reads");

  AST_SNAP_READBACK: assert property (@(posedge clk) disable iff (reset)
    s_snap_read |=> avs_readdata[7:0] == $past(count_snapshot_q))
    else $error("snapshot read returned wrong data");

  AST_HALF_HOLD: assert property (@(posedge clk) disable iff (reset)
    !underflow |=> $stable(half_clk_q))
    else $error("half clock moved without an underflow");

  AST_IRQ_ON: assert property (@(posedge clk) disable iff (reset)
    (pending_q[`EBRT_BIT_UNDERFLOW] && irq_allow_q[7]) |=> irq)
    else $error("allowed pending underflow raised no interrupt");
endmodule

// >>> tb/ebrt_testbench.sv
/*
 Self-checking bench for the reload timer register block.
 Assumes the package is compiled first and the params header is on the include path.
*/
`timescale 1ns/100ps
`include "ebrt_params.svh"
module testbench;
  import ebrt_pkg::*;
  localparam logic [23:0] ctl = `EBRT_IDX_CONTROL;
  localparam logic [23:0] reload_value = `EBRT_IDX_RELOAD;
  localparam logic [23:0] snp = `EBRT_IDX_SNAPSHOT;
  localparam logic [23:0] pnd = `EBRT_IDX_PENDING;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [25:0] avs_address = 26'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic serial_clock_out;
  logic irq;
  logic [31:0] rd;
  logic [31:0] keep;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  always #10 clk = ~clk;
  ebrt_timer dut_u (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_clock_out(serial_clock_out), .irq(irq));
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [23:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk("bus answer", 32'h0, (k == 50) ? 32'h1 : 32'h0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [23:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, exp, rd);
  endtask
  // Counts clocks to the next rising edge of the serial clock
  task automatic wait_rise(output int cnt);
    cnt = 0;
    while (serial_clock_out !== 1'b0 && cnt < 300) begin
      @(negedge clk);
      cnt++;
    end
    while (serial_clock_out !== 1'b1 && cnt < 300) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task automatic test_reset();
    rchk("control", ctl, 32'h0);
    rchk("reload", reload_value, 32'hFF);
    rchk("snapshot", snp, 32'hFF);
    rchk("pending", pnd, 32'h0);
    rchk("unmapped", 24'h00FF30, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    chk("serial", 32'h0, {31'h0, serial_clock_out});
    $display("reset test done");
  endtask
  task automatic test_control();
    bus(1'b1, ctl, 8'hFF);
    rchk("control", ctl, 32'h05);
    bus(1'b1, ctl, 8'h00);
    @(posedge clk);
    avs_byteenable <= 4'h0;
    bus(1'b1, reload_value, 8'h00);
    avs_byteenable <= 4'hF;
    rchk("reload lane off", reload_value, 32'hFF);
    $display("control test done");
  endtask
  task automatic test_preset_hold();
    bus(1'b1, `EBRT_IDX_TIMER_DIV, 8'h00);
    rchk("divider", `EBRT_IDX_TIMER_DIV, 32'h0);
    bus(1'b1, reload_value, 8'h03);
    bus(1'b1, ctl, 8'h02);
    bus(1'b1, pnd, 8'h80);
    rchk("pending", pnd, 32'h0);
    rchk("preset", snp, 32'h03);
    repeat (20) @(posedge clk);
    rchk("halted", snp, 32'h03);
    $display("preset test done");
  endtask
  task automatic test_underflow();
    bus(1'b1, ctl, 8'h01);
    repeat (30) @(posedge clk);
    bus(1'b1, ctl, 8'h00);
    rchk("pending set", pnd, 32'h80);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b0, snp, 8'h00);
    keep = rd;
    repeat (10) @(posedge clk);
    rchk("stopped", snp, keep);
    bus(1'b1, pnd, 8'h00);
    rchk("zero write", pnd, 32'h80);
    bus(1'b1, `EBRT_IDX_IRQ_ALLOW, 8'h80);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    rchk("allow", `EBRT_IDX_IRQ_ALLOW, 32'h80);
    bus(1'b1, pnd, 8'h80);
    repeat (2) @(posedge clk);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("underflow test done");
  endtask
  task automatic test_serial();
    keep = 32'h0;
    bus(1'b1, ctl, 8'h01);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      keep = keep | {31'h0, serial_clock_out};
    end
    chk("gate off", 32'h0, keep);
    bus(1'b1, ctl, 8'h07);
    wait_rise(n);
    wait_rise(n);
    chk("period", 32'd8, n);
    bus(1'b1, ctl, 8'h00);
    $display("serial test done");
  endtask
  // Whole run is a few hundred cycles; generous margin
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_control();
    test_preset_hold();
    test_underflow();
    test_serial();
    finish_test();
  end
endmodule
